/* File: lpms_defines.vh */
`ifndef LPMS_DEFINES_VH
`define LPMS_DEFINES_VH

// mode selection values
`define LPMS_MODE_STANDBY      1'b0
`define LPMS_MODE_HALT         1'b1

// flush hold of the system clock, in system clock cycles
`define LPMS_FLUSH_SHORT       18'h00020
`define LPMS_FLUSH_LONG        18'h00040

// idle instruction to clock output low, system clock cycles
`define LPMS_CLKOUT_MIN        18'h00020
`define LPMS_CLKOUT_MAX        18'h0002d

// resume latencies in system clock cycles
`define LPMS_STBY_RESUME       18'h00064
`define LPMS_STBY_RESUME_SLEEP 18'h00465
`define LPMS_HALT_RESUME_SLEEP 18'h00465
`define LPMS_HALT_RESUME_RAM   18'h00023

// pll lock wait in oscillator clock cycles
`define LPMS_PLL_LOCK          131072

// wake qualification extra oscillator cycles
`define LPMS_QUAL_EXTRA        7'h02

// oscillator cycles after idle before a wake may count
`define LPMS_WAKE_GUARD        3'h4

// default system clock cycles per oscillator clock cycle
`define LPMS_OSC_DIV           10

`endif

/* File: lpms_timer.v */
`timescale 1ns/10ps
`default_nettype none

// loadable down counter; done_out pulses after the last decrement
module lpms_timer #(
    parameter WIDTH = 18
) (
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] value_in,
    input  wire             tick_in,
    output reg  [WIDTH-1:0] count_out,
    output reg              done_out
);

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            count_out <= {WIDTH{1'b0}};
            done_out  <= 1'b0;
        end
        else if (load_in)
        begin
            count_out <= value_in;
            done_out  <= 1'b0;
        end
        else if (tick_in && (count_out != {WIDTH{1'b0}}))
        begin
            count_out <= count_out - {{(WIDTH-1){1'b0}}, 1'b1};
            done_out  <= (count_out == {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else
        begin
            done_out  <= 1'b0;
        end
    end

endmodule // lpms_timer

`default_nettype wire

/* File: lpms_sequencer.v */
// Notes on behaviour
// - clock output low 32 to 45 cycles after idle
// - standby holds system clock 32 or 64 cycles
// - standby stops peripherals, pll and watchdog run
// - standby resume within 100 or 1125 cycles
// - latency measured to instruction after idle
// - halt holds clock, then stops crystal oscillator, core
// - halt stops peripherals, pll, crystal oscillator
// - low wake pin restarts oscillator in halt
// - wait 131072 oscillator cycles for pll lock
// - halt resume within 1125 or 35 cycles
// - clocks back on, then wake interrupt if enabled
// - standby wake qualified count plus 2 cycles
`timescale 1ns/10ps
`default_nettype none
`include "lpms_defines.vh"

module lpms_sequencer #(
    parameter [31:0] PLL_LOCK_CYCLES = `LPMS_PLL_LOCK,
    parameter [31:0] OSC_DIV         = `LPMS_OSC_DIV
) (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       idle_exec_in,
    input  wire       lowpower_mode_in,
    input  wire       input_clock_halving_in,
    input  wire       wake_qualify_enable_in,
    input  wire [5:0] standby_wake_qualify_count_in,
    input  wire       flash_sleep_in,
    input  wire       crystal_source_in,
    input  wire       wake_irq_enable_in,
    input  wire       wake_pin_in,
    input  wire       external_reset_pin_n_in,
    input  wire       osc_stable_in,
    output reg        clock_output_pin_out,
    output reg        system_clock_en_out,
    output reg        core_clock_input_en_out,
    output reg        periph_clock_en_out,
    output reg        pll_enable_out,
    output reg        osc_enable_out,
    output reg        resume_out,
    output reg        wake_irq_out,
    output reg        lowpower_active_out
);

    localparam [6:0] ST_RUN     = 7'h01;
    localparam [6:0] ST_FLUSH   = 7'h02;
    localparam [6:0] ST_STBY    = 7'h04;
    localparam [6:0] ST_HALT    = 7'h08;
    localparam [6:0] ST_OSCWAIT = 7'h10;
    localparam [6:0] ST_LOCK    = 7'h20;
    localparam [6:0] ST_RESUME  = 7'h40;
    localparam [31:0] DIV_FULL = OSC_DIV - 32'h1;
    localparam [17:0] LOCK_LEN = PLL_LOCK_CYCLES[17:0];
    localparam [7:0]  DIV_LAST = DIV_FULL[7:0];

    reg  [6:0]  state_q;
    reg         mode_q;
    reg  [17:0] flush_len_q;
    reg  [1:0]  wake_sync_q;
    reg  [1:0]  rst_sync_q;
    reg  [1:0]  stable_sync_q;
    reg  [7:0]  div_q;
    reg         osc_tick_q;
    reg  [2:0]  guard_q;
    reg  [6:0]  qual_q;
    reg         load_q;
    reg  [17:0] load_val_q;
    wire [17:0] tmr_count;
    wire        tmr_done;
    wire        tmr_tick;
    wire        wake_low;
    wire        xrs_low;
    wire        guard_done;
    wire        wake_qualified;

    // pins pass two flops before use
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wake_sync_q   <= 2'h3;
            rst_sync_q    <= 2'h3;
            stable_sync_q <= 2'h0;
        end
        else
        begin
            wake_sync_q   <= {wake_sync_q[0], wake_pin_in};
            rst_sync_q    <= {rst_sync_q[0], external_reset_pin_n_in};
            stable_sync_q <= {stable_sync_q[0], osc_stable_in};
        end
    end

    assign wake_low = ~wake_sync_q[1];
    assign xrs_low  = ~rst_sync_q[1];

    // oscillator clock tick, absent while the oscillator is off
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            div_q      <= 8'h00;
            osc_tick_q <= 1'b0;
        end
        else if (!osc_enable_out)
        begin
            div_q      <= 8'h00;
            osc_tick_q <= 1'b0;
        end
        else
        begin
            osc_tick_q <= (div_q == DIV_LAST);
            div_q      <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
        end
    end

    // wake guard from idle, and standby wake qualification
    always @(posedge clk_in)
    begin
        if (rst_in || (state_q == ST_RUN))
        begin
            guard_q <= 3'h0;
        end
        else if (osc_tick_q && !guard_done)
        begin
            guard_q <= guard_q + 3'h1;
        end
    end

    assign guard_done = (guard_q >= `LPMS_WAKE_GUARD);

    always @(posedge clk_in)
    begin
        if (rst_in || !wake_low || (state_q != ST_STBY))
        begin
            qual_q <= 7'h00;
        end
        else if (osc_tick_q && (qual_q != 7'h7f))
        begin
            qual_q <= qual_q + 7'h01;
        end
    end

    assign wake_qualified = wake_qualify_enable_in ?
        (qual_q >= ({1'b0, standby_wake_qualify_count_in} +
                    `LPMS_QUAL_EXTRA)) : wake_low;

    // lock wait counts oscillator cycles, all else system cycles
    assign tmr_tick = (state_q == ST_LOCK) ? osc_tick_q : 1'b1;

    lpms_timer #(
        .WIDTH(18)
    ) u_timer (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .load_in   (load_q),
        .value_in  (load_val_q),
        .tick_in   (tmr_tick),
        .count_out (tmr_count),
        .done_out  (tmr_done)
    );

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q                 <= ST_RUN;
            mode_q                  <= `LPMS_MODE_STANDBY;
            flush_len_q             <= `LPMS_FLUSH_SHORT;
            load_q                  <= 1'b0;
            load_val_q              <= 18'h00000;
            clock_output_pin_out    <= 1'b1;
            system_clock_en_out     <= 1'b1;
            core_clock_input_en_out <= 1'b1;
            periph_clock_en_out     <= 1'b1;
            pll_enable_out          <= 1'b1;
            osc_enable_out          <= 1'b1;
            resume_out              <= 1'b0;
            wake_irq_out            <= 1'b0;
            lowpower_active_out     <= 1'b0;
        end
        else
        begin
            load_q       <= 1'b0;
            resume_out   <= 1'b0;
            wake_irq_out <= 1'b0;
            case (state_q)
                ST_RUN:
                begin
                    if (idle_exec_in)
                    begin
                        mode_q              <= lowpower_mode_in;
                        flush_len_q         <= input_clock_halving_in ?
                            `LPMS_FLUSH_LONG : `LPMS_FLUSH_SHORT;
                        load_val_q          <= input_clock_halving_in ?
                            `LPMS_FLUSH_LONG : `LPMS_FLUSH_SHORT;
                        load_q              <= 1'b1;
                        lowpower_active_out <= 1'b1;
                        state_q             <= ST_FLUSH;
                    end
                end
                ST_FLUSH:
                begin
                    if (!load_q &&
                        (tmr_count <= flush_len_q - `LPMS_CLKOUT_MIN))
                    begin
                        clock_output_pin_out <= 1'b0;
                    end
                    if (tmr_done)
                    begin
                        system_clock_en_out     <= 1'b0;
                        core_clock_input_en_out <= 1'b0;
                        periph_clock_en_out     <= 1'b0;
                        if (mode_q == `LPMS_MODE_HALT)
                        begin
                            pll_enable_out <= 1'b0;
                            osc_enable_out <= ~crystal_source_in;
                            state_q        <= ST_HALT;
                        end
                        else
                        begin
                            state_q <= ST_STBY;
                        end
                    end
                end
                ST_STBY:
                begin
                    if (guard_done && wake_qualified)
                    begin
                        system_clock_en_out     <= 1'b1;
                        core_clock_input_en_out <= 1'b1;
                        periph_clock_en_out     <= 1'b1;
                        clock_output_pin_out    <= 1'b1;
                        load_val_q              <= flash_sleep_in ?
                            `LPMS_STBY_RESUME_SLEEP :
                            `LPMS_STBY_RESUME;
                        load_q                  <= 1'b1;
                        state_q                 <= ST_RESUME;
                    end
                end
                ST_HALT:
                begin
                    if (guard_done && (wake_low || xrs_low))
                    begin
                        osc_enable_out <= 1'b1;
                        state_q        <= ST_OSCWAIT;
                    end
                end
                ST_OSCWAIT:
                begin
                    if (stable_sync_q[1])
                    begin
                        pll_enable_out <= 1'b1;
                        load_val_q     <= LOCK_LEN;
                        load_q         <= 1'b1;
                        state_q        <= ST_LOCK;
                    end
                end
                ST_LOCK:
                begin
                    if (tmr_done)
                    begin
                        system_clock_en_out     <= 1'b1;
                        core_clock_input_en_out <= 1'b1;
                        periph_clock_en_out     <= 1'b1;
                        clock_output_pin_out    <= 1'b1;
                        load_val_q              <= flash_sleep_in ?
                            `LPMS_HALT_RESUME_SLEEP :
                            `LPMS_HALT_RESUME_RAM;
                        load_q                  <= 1'b1;
                        state_q                 <= ST_RESUME;
                    end
                end
                ST_RESUME:
                begin
                    if (tmr_done)
                    begin
                        resume_out          <= 1'b1;
                        wake_irq_out        <= wake_irq_enable_in;
                        lowpower_active_out <= 1'b0;
                        state_q             <= ST_RUN;
                    end
                end
                default:
                begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

endmodule // lpms_sequencer

`default_nettype wire

/* File: lpms_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module lpms_checker #(
    parameter PLL_LOCK_CYCLES = 131072,
    parameter OSC_DIV         = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic idle_exec_in,
    input wire logic lowpower_mode_in,
    input wire logic input_clock_halving_in,
    input wire logic flash_sleep_in,
    input wire logic crystal_source_in,
    input wire logic wake_irq_enable_in,
    input wire logic clock_output_pin_out,
    input wire logic system_clock_en_out,
    input wire logic core_clock_input_en_out,
    input wire logic periph_clock_en_out,
    input wire logic pll_enable_out,
    input wire logic osc_enable_out,
    input wire logic resume_out,
    input wire logic wake_irq_out,
    input wire logic lowpower_active_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic        take;
    logic        pll_q;
    logic [31:0] lock_q;
    logic [11:0] wake_q;
    assign take = idle_exec_in && !lowpower_active_out;
    // edges since the pll was last switched on
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pll_q  <= 1'b1;
            lock_q <= 32'h0;
        end
        else
        begin
            pll_q  <= pll_enable_out;
            lock_q <= (pll_enable_out && !pll_q) ? 32'h0 : lock_q + 32'h1;
        end
    end
    // edges since the core clock came back, while still asleep
    always @(posedge clk_in)
    begin
        if (rst_in || !core_clock_input_en_out || !lowpower_active_out)
            wake_q <= 12'h000;
        else if (wake_q != 12'hfff)
            wake_q <= wake_q + 12'h001;
    end
    clkout_low_a:
    assert property (take |-> ##[32:45] $fell(clock_output_pin_out))
        else $error("clock output low out of window");
    flush_short_a:
    assert property (take && !input_clock_halving_in |->
        ##31 system_clock_en_out ##[1:4] !system_clock_en_out)
        else $error("short flush length wrong");
    flush_long_a:
    assert property (take && input_clock_halving_in |->
        ##63 system_clock_en_out ##[1:4] !system_clock_en_out)
        else $error("long flush length wrong");
    stby_gate_a:
    assert property (take && !lowpower_mode_in && !input_clock_halving_in
        |-> ##40 (!periph_clock_en_out && pll_enable_out && osc_enable_out))
        else $error("standby gating wrong");
    halt_gate_a:
    assert property (take && lowpower_mode_in && !input_clock_halving_in
        |-> ##40 (!periph_clock_en_out && !core_clock_input_en_out
        && !pll_enable_out && osc_enable_out == !crystal_source_in))
        else $error("halt gating wrong");
    sleep_resume_a:
    assert property (lowpower_active_out && flash_sleep_in |->
        wake_q <= 12'h467) else $error("slow resume, flash asleep");
    stby_resume_a:
    assert property ($rose(core_clock_input_en_out) && !flash_sleep_in &&
        !lowpower_mode_in |-> ##[1:103] resume_out)
        else $error("slow standby resume");
    halt_resume_a:
    assert property ($rose(core_clock_input_en_out) && !flash_sleep_in &&
        lowpower_mode_in |-> ##[1:38] resume_out)
        else $error("slow halt resume");
    irq_pair_a:
    assert property (wake_irq_out == (resume_out && wake_irq_enable_in))
        else $error("wake irq not paired with resume");
    lock_wait_a:
    assert property ($rose(core_clock_input_en_out) && lowpower_mode_in |->
        lock_q >= (PLL_LOCK_CYCLES - 1) * OSC_DIV &&
        lock_q <= (PLL_LOCK_CYCLES + 2) * OSC_DIV + 8)
        else $error("pll lock wait wrong");
endmodule // lpms_checker
bind lpms_sequencer lpms_checker #(
    .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .OSC_DIV(OSC_DIV)
) lpms_checker_inst (
    .clk_in, .rst_in, .idle_exec_in, .lowpower_mode_in,
    .input_clock_halving_in, .flash_sleep_in, .crystal_source_in,
    .wake_irq_enable_in, .clock_output_pin_out, .system_clock_en_out,
    .core_clock_input_en_out, .periph_clock_en_out, .pll_enable_out,
    .osc_enable_out, .resume_out, .wake_irq_out, .lowpower_active_out
);
`default_nettype wire

/* File: lpms_wake_source.sv */
`timescale 1ns/10ps
`default_nettype none
module lpms_wake_source (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       fire_in,
    input  wire logic       use_reset_in,
    input  wire logic [4:0] hold_in,
    input  wire logic       osc_stable_in,
    output wire logic       wake_pin_out,
    output wire logic       reset_pin_n_out
);
    logic       busy_q;
    logic       sel_q;
    logic [4:0] cnt_q;
    always @(posedge clk_in)
    begin
        if (rst_in)
            busy_q <= 1'b0;
        else if (fire_in && !busy_q)
        begin
            busy_q <= 1'b1;
            sel_q <= use_reset_in;
            cnt_q <= hold_in;
        end
        else if (busy_q && osc_stable_in)
        begin
            if (cnt_q == 5'h00)
                busy_q <= 1'b0;
            else
                cnt_q <= cnt_q - 5'h01;
        end
    end
    // pulled-up lines: one clean low pulse, high when released
    assign wake_pin_out = !(busy_q && !sel_q);
    assign reset_pin_n_out = !(busy_q && sel_q);
endmodule // lpms_wake_source
`default_nettype wire

/* File: lpms_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module lpms_sequencer_tb;
    logic clk_in, rst_in = 1'b1, idle_exec_in = 1'b0;
    logic lowpower_mode_in = 1'b0, input_clock_halving_in = 1'b0;
    logic wake_qualify_enable_in = 1'b0, flash_sleep_in = 1'b0;
    logic [5:0] standby_wake_qualify_count_in = 6'h00;
    logic crystal_source_in = 1'b0, wake_irq_enable_in = 1'b0;
    logic wake_pin_in, external_reset_pin_n_in, osc_stable_in;
    logic clock_output_pin_out, system_clock_en_out, resume_out;
    logic core_clock_input_en_out, periph_clock_en_out, pll_enable_out;
    logic osc_enable_out, wake_irq_out, lowpower_active_out;
    logic fire = 1'b0, use_rst = 1'b0;
    logic [4:0] hold = 5'h00;
    logic [3:0] stable_q = 4'h0;
    logic [3:0] gates;
    logic [2:0] mon;
    logic [31:0] seed;
    int err_total, compares, i;
    lpms_sequencer #(.PLL_LOCK_CYCLES(20), .OSC_DIV(2)) lpms_sequencer_inst (
        .clk_in, .rst_in, .idle_exec_in, .lowpower_mode_in,
        .input_clock_halving_in, .wake_qualify_enable_in,
        .standby_wake_qualify_count_in, .flash_sleep_in, .crystal_source_in,
        .wake_irq_enable_in, .wake_pin_in, .external_reset_pin_n_in,
        .osc_stable_in, .clock_output_pin_out, .system_clock_en_out,
        .core_clock_input_en_out, .periph_clock_en_out, .pll_enable_out,
        .osc_enable_out, .resume_out, .wake_irq_out, .lowpower_active_out);
    lpms_wake_source lpms_wake_source_inst (.clk_in, .rst_in, .fire_in(fire),
        .use_reset_in(use_rst), .hold_in(hold), .osc_stable_in,
        .wake_pin_out(wake_pin_in), .reset_pin_n_out(external_reset_pin_n_in));
    assign gates = {core_clock_input_en_out, periph_clock_en_out,
                    pll_enable_out, osc_enable_out};
    assign mon = {clock_output_pin_out, system_clock_en_out, resume_out};
    // oscillator reports stable a few edges after it is enabled
    always @(posedge clk_in) stable_q <= {stable_q[2:0], osc_enable_out};
    assign osc_stable_in = stable_q[3];
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // {periph, pll, osc} enables while asleep
    function automatic logic [2:0] asleep(input logic m, input logic x);
        return m ? {2'b00, !x} : 3'b011;
    endfunction
    function automatic int stby_max(input logic s, input logic q, int c);
        return (s ? 1125 : 100) + 10 + (q ? (c + 2) * 2 + 2 : 0);
    endfunction
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_for(int k, logic v, int lim, output int n);
        n = 0;
        while (mon[k] !== v && n < lim)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask
    task automatic pulse(logic r, logic [4:0] h);
        @(posedge clk_in);
        use_rst <= r;
        hold <= h;
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
    endtask
    task automatic op(logic m, logic ur, logic q, int sp);
        int n, lim;
        seed = lfsr(seed);
        @(posedge clk_in);
        lowpower_mode_in <= m;
        input_clock_halving_in <= seed[0];
        flash_sleep_in <= seed[1];
        crystal_source_in <= seed[2];
        wake_irq_enable_in <= seed[3];
        wake_qualify_enable_in <= q;
        standby_wake_qualify_count_in <= {3'h0, seed[6:4]};
        idle_exec_in <= 1'b1;
        @(posedge clk_in);
        idle_exec_in <= 1'b0;
        wait_for(2, 1'b0, 80, n);
        check("idle to clock low", 1, n >= 32 && n <= 45);
        wait_for(1, 1'b0, 80, n);
        repeat (10) @(posedge clk_in);
        #1;
        check("gated clocks", {1'b0, asleep(m, seed[2])}, gates);
        if (!m && (ur || sp > 0))
        begin
            pulse(ur, sp[4:0]);
            repeat (40) @(posedge clk_in);
            #1;
            check("asleep after refused wake", 0, system_clock_en_out);
        end
        pulse(ur && m, 5'h18);
        wait_for(0, 1'b1, 3000, n);
        check("resume seen", 1, resume_out);
        check("irq with resume", wake_irq_enable_in, wake_irq_out);
        check("clocks at resume", 4'hf, gates);
        lim = stby_max(seed[1], q, seed[6:4]);
        if (!m)
            check("standby resume", 1, n <= lim);
        @(posedge clk_in);
        #1;
        check("active after resume", 0, lowpower_active_out);
    endtask
    task automatic conclude();
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        seed = 32'h0e929c88;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        op(1'b0, 1'b1, 1'b0, 0);
        op(1'b0, 1'b0, 1'b1, 1);
        op(1'b1, 1'b1, 1'b0, 0);
        for (i = 0; i < 6; i++)
            op(seed[8], 1'b0, seed[9], 0);
        conclude();
    end
    initial
    begin
        #200000;
        err_total++;
        conclude();
    end
endmodule // lpms_sequencer_tb
`default_nettype wire
